// File: rtl/flash_end.sv
// Flash end: parameter table read, soft reset pair and status writes
`include "sfdp_cfg.svh"
`default_nettype none
module flash_end (
  input wire logic core_clk_i,
  input wire logic rst_i,
  spi_link_if.flash link,
  input wire sfdp_pkg::lane_t bus_width_i,
  output logic [7:0] status_o,
  output logic [7:0] nv_status_o,
  output logic wel_o,
  output logic vol_en_o,
  output logic reset_armed_o,
  output logic soft_reset_o
);
  import sfdp_pkg::*;

  logic [5:0] meta;
  logic [5:0] pin;
  logic sclk_d;
  logic cs_d;
  lane_t lane;
  dev_st_t st;
  logic [2:0] bitcnt;
  logic [7:0] sh;
  logic [7:0] op;
  logic [3:0] nbytes;
  logic [23:0] addr;
  logic [7:0] wbyte;
  logic [5:0] sr_hi;
  logic [5:0] nv_hi = `NV_SR_INIT;
  logic wel;
  logic vol_en;
  logic armed;
  logic [3:0] dev_io;
  logic [3:0] dev_io_oe_n;

  logic sclk_s;
  logic cs_s;
  logic [3:0] io_s;
  logic rise;
  logic fall;
  logic frame_end;
  logic [3:0] sum;
  logic [7:0] next_sh;
  logic [7:0] out_byte;
  logic [7:0] status;
  logic one_byte;

  function automatic logic [2:0] lane_step(input lane_t l);
    case (l)
      L4: lane_step = 3'h4;
      L2: lane_step = 3'h2;
      default: lane_step = 3'h1;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] io,
                                          input lane_t l);
    case (l)
      L4: shift_in = {s[3:0], io};
      L2: shift_in = {s[5:0], io[1:0]};
      default: shift_in = {s[6:0], io[0]};
    endcase
  endfunction

  // Next lanes to drive, most significant bits first
  function automatic logic [3:0] out_slice(input logic [7:0] b, input logic [2:0] c,
                                           input lane_t l);
    logic [7:0] t;
    t = b << c;
    case (l)
      L4: out_slice = t[7:4];
      L2: out_slice = {2'h0, t[7:6]};
      default: out_slice = {2'h0, t[7], 1'h0};
    endcase
  endfunction

  function automatic logic [3:0] out_enable_n(input lane_t l);
    case (l)
      L4: out_enable_n = 4'h0;
      L2: out_enable_n = 4'hc;
      default: out_enable_n = 4'hd;
    endcase
  endfunction

  // Only one parameter doubleword is held; every other address reads fill
  function automatic logic [7:0] sfdp_byte(input logic [23:0] a);
    logic [31:0] dw;
    dw = {`ENTER4B_FIELD, `EXIT4B_FIELD, `SRST_FIELD,
          `DW16_RFU7, `SR1_WR_FIELD};
    sfdp_byte = `SFDP_FILL;
    if (a[23:2] == `SFDP_DW16_WORD) begin
      case (a[1:0])
        2'h0: sfdp_byte = dw[7:0];
        2'h1: sfdp_byte = dw[15:8];
        2'h2: sfdp_byte = dw[23:16];
        default: sfdp_byte = dw[31:24];
      endcase
    end
  endfunction

  // Pins come from the link clock's domain
  always_ff @(posedge core_clk_i) begin
    meta <= {link.sclk, link.cs_n, link.io_bus};
    pin <= meta;
  end

  assign sclk_s = pin[5];
  assign cs_s = pin[4];
  assign io_s = pin[3:0];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d <= cs_s;
    end
  end

  assign rise = sclk_s && !sclk_d && !cs_s;
  assign fall = !sclk_s && sclk_d && !cs_s;
  assign frame_end = cs_s && !cs_d;
  assign sum = {1'b0, bitcnt} + {1'b0, lane_step(lane)};
  assign next_sh = shift_in(sh, io_s, lane);
  assign status = {sr_hi, wel, 1'b0};
  assign out_byte = (op == `OP_RDSR) ? status : sfdp_byte(addr);
  assign one_byte = (nbytes == 4'h1) && (bitcnt == 3'h0);

  // Width is taken between frames, so a frame never changes width midway
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lane <= L1;
    end else if (cs_s) begin
      lane <= bus_width_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || cs_s) begin
      st <= DS_OP;
      bitcnt <= 3'h0;
      sh <= 8'h00;
      op <= 8'h00;
      nbytes <= 4'h0;
      addr <= 24'h000000;
      wbyte <= 8'h00;
    end else if (rise) begin
      sh <= next_sh;
      if (sum[3]) begin
        bitcnt <= 3'h0;
        if (nbytes != 4'hf) begin
          nbytes <= nbytes + 4'h1;
        end
        case (st)
          DS_OP: begin
            op <= next_sh;
            if (next_sh == `OP_RDSFDP) begin
              st <= DS_ADDR;
            end else if (next_sh == `OP_RDSR) begin
              st <= DS_DATA;
            end else if (next_sh == `OP_WRSR) begin
              st <= DS_WDATA;
            end else begin
              st <= DS_DONE;
            end
          end
          DS_ADDR: begin
            addr <= {addr[15:0], next_sh};
            if (nbytes == {1'b0, `ADDR_BYTES}) begin
              st <= DS_DUMMY;
            end
          end
          DS_DUMMY: st <= DS_DATA;
          DS_DATA: addr <= addr + 24'h000001;
          DS_WDATA: begin
            wbyte <= next_sh;
            st <= DS_DONE;
          end
          default: st <= DS_DONE;
        endcase
      end else begin
        bitcnt <= sum[2:0];
      end
    end
  end

  // Output changes on the falling edge so it is settled for the host's rise
  always_ff @(posedge core_clk_i) begin
    if (rst_i || cs_s) begin
      dev_io <= 4'h0;
      dev_io_oe_n <= 4'hf;
    end else if (fall && st == DS_DATA) begin
      dev_io <= out_slice(out_byte, bitcnt, lane);
      dev_io_oe_n <= out_enable_n(lane);
    end
  end

  // Instructions act when the frame closes; the reset pair and the enables need exactly one whole byte
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      armed <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= 1'b0;
      if (frame_end && nbytes != 4'h0) begin
        armed <= one_byte && op == `OP_RST_EN;
        if (one_byte && op == `OP_RST && armed) begin
          soft_reset_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wel <= 1'b0;
      vol_en <= 1'b0;
    end else if (frame_end && nbytes != 4'h0) begin
      if (one_byte && op == `OP_RST && armed) begin
        wel <= 1'b0;
        vol_en <= 1'b0;
      end else if (one_byte && op == `OP_WREN) begin
        wel <= 1'b1;
      end else if (one_byte && op == `OP_VWREN) begin
        vol_en <= 1'b1;
      end else if (op == `OP_WRSR) begin
        wel <= 1'b0;
        vol_en <= 1'b0;
      end
    end
  end

  // A status write needs its data byte complete; partial frames are dropped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sr_hi <= nv_hi;
    end else if (frame_end && op == `OP_WRSR && nbytes == 4'h2 && bitcnt == 3'h0) begin
      if (wel || vol_en) begin
        sr_hi <= wbyte[7:2];
      end
    end
  end

  // No reset here: this copy stands in for storage that survives power loss
  always_ff @(posedge core_clk_i) begin
    if (!rst_i && frame_end && op == `OP_WRSR && nbytes == 4'h2 && bitcnt == 3'h0
        && wel) begin
      nv_hi <= wbyte[7:2];
    end
  end

  assign link.dev_io = dev_io;
  assign link.dev_io_oe_n = dev_io_oe_n;
  assign status_o = status;
  assign nv_status_o = {nv_hi, 2'h0};
  assign wel_o = wel;
  assign vol_en_o = vol_en;
  assign reset_armed_o = armed;
endmodule
`default_nettype wire

// File: rtl/host_end.sv
// Controller end: Avalon-MM registers driving serial instruction frames
`include "sfdp_cfg.svh"
`default_nettype none
module host_end #(
  parameter int HALF_CYC = `SCLK_HALF_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  spi_link_if.ctrl link
);
  import sfdp_pkg::*;

  host_st_t st;
  logic [7:0] half_cnt;
  logic [14:0] cmd;
  logic [31:0] tx;
  logic [31:0] rx;
  lane_t lane;
  logic cont;
  logic wen_seen;
  logic exit_phase;
  logic rd_ack;
  logic [39:0] sh;
  logic [6:0] ci;
  logic [6:0] n_out;
  logic [6:0] n_in0;
  logic [6:0] n_total;
  logic [3:0] meta;
  logic [3:0] pin;
  logic sclk;
  logic cs_n;
  logic [3:0] io_o;
  logic [3:0] oe_n;

  logic start;
  logic half_done;
  logic [2:0] step;
  logic [6:0] cpb;
  logic busy;

  assign step = (lane == L4) ? 3'h4 : ((lane == L2) ? 3'h2 : 3'h1);
  assign cpb = 7'h08 >> step[2:1];
  assign busy = st != HS_IDLE;
  assign start = avs_write && avs_address == `REG_CMD && !busy;
  assign half_done = half_cnt == 8'(HALF_CYC - 1);
  // A command written while a frame runs is held off, not lost
  assign avs_waitrequest = (avs_read && !rd_ack) ||
                           (avs_write && avs_address == `REG_CMD && busy);

  always_ff @(posedge core_clk_i) begin
    meta <= link.io_bus;
    pin <= meta;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_ack <= avs_read && !rd_ack;
      if (avs_read && !rd_ack) begin
        if (avs_address == `REG_TX) begin
          avs_readdata <= tx;
        end else if (avs_address == `REG_RX) begin
          avs_readdata <= rx;
        end else if (avs_address == `REG_STAT) begin
          avs_readdata <= {28'h0000000, wen_seen, cont, exit_phase, busy};
        end else if (avs_address == `REG_CFG) begin
          avs_readdata <= {29'h00000000, cont, lane};
        end else if (avs_address == `REG_CMD) begin
          avs_readdata <= {17'h00000, cmd};
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx <= 32'h00000000;
      lane <= L1;
    end else if (avs_write && avs_address == `REG_TX) begin
      tx <= avs_writedata;
    end else if (avs_write && avs_address == `REG_CFG && !busy) begin
      lane <= (avs_writedata[`CFG_LANE] == 2'h3) ? L4 : lane_t'(avs_writedata[`CFG_LANE]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wen_seen <= 1'b0;
    end else if (start) begin
      if (avs_writedata[`CMD_OP] == `OP_WREN || avs_writedata[`CMD_OP] == `OP_VWREN) begin
        wen_seen <= 1'b1;
      end else if (avs_writedata[`CMD_OP] == `OP_WRSR) begin
        wen_seen <= 1'b0;
      end
    end
  end

  // Frame sequencer; the mode-exit frame runs before a reset-enable instruction when continuous read may be on
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= HS_IDLE;
      half_cnt <= 8'h00;
      cmd <= 15'h0000;
      cont <= 1'b0;
      exit_phase <= 1'b0;
      sh <= 40'h0;
      ci <= 7'h00;
      n_out <= 7'h00;
      n_in0 <= 7'h00;
      n_total <= 7'h00;
      rx <= 32'h00000000;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      io_o <= 4'h0;
      oe_n <= 4'hf;
    end else begin
      half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
      case (st)
        HS_IDLE: begin
          half_cnt <= 8'h00;
          if (avs_write && avs_address == `REG_CFG) begin
            cont <= avs_writedata[`CFG_CONT];
          end
          if (start) begin
            cmd <= avs_writedata[14:0];
            ci <= 7'h00;
            cs_n <= 1'b0;
            st <= HS_LOW;
            if (cont && avs_writedata[`CMD_OP] == `OP_RST_EN) begin
              exit_phase <= 1'b1;
              n_out <= `EXIT_MODE_CLKS;
              n_in0 <= `EXIT_MODE_CLKS;
              n_total <= `EXIT_MODE_CLKS;
              sh <= {10{`EXIT_MODE_NIBBLE}};
              io_o <= `EXIT_MODE_NIBBLE;
              oe_n <= 4'h0;
            end else begin
              n_out <= 7'((4'h1 + {1'b0, avs_writedata[`CMD_TXN]}) * cpb);
              n_in0 <= 7'((4'h1 + {1'b0, avs_writedata[`CMD_TXN]}
                           + {3'h0, avs_writedata[`CMD_DUMMY]}) * cpb);
              n_total <= 7'((4'h1 + {1'b0, avs_writedata[`CMD_TXN]}
                             + {3'h0, avs_writedata[`CMD_DUMMY]}
                             + {1'b0, avs_writedata[`CMD_RXN]}) * cpb);
              sh <= {avs_writedata[`CMD_OP], tx << (6'(3'h4 - avs_writedata[`CMD_TXN]) * 6'h08)}
                    << step;
              io_o <= (lane == L4) ? avs_writedata[7:4] :
                      ((lane == L2) ? {2'h0, avs_writedata[7:6]} : {3'h0, avs_writedata[7]});
              oe_n <= (lane == L4) ? 4'h0 : ((lane == L2) ? 4'hc : 4'he);
            end
          end
        end
        HS_LOW: if (half_done) begin
          sclk <= 1'b1;
          st <= HS_HIGH;
          if (!exit_phase && ci >= n_in0) begin
            rx <= (lane == L4) ? {rx[27:0], pin[3:0]} :
                  ((lane == L2) ? {rx[29:0], pin[1:0]} : {rx[30:0], pin[1]});
          end
        end
        HS_HIGH: if (half_done) begin
          sclk <= 1'b0;
          ci <= ci + 7'h01;
          if (ci + 7'h01 == n_total) begin
            st <= HS_END;
          end else begin
            st <= HS_LOW;
            if (ci + 7'h01 < n_out) begin
              io_o <= (lane == L4 || exit_phase) ? sh[39:36] :
                      ((lane == L2) ? {2'h0, sh[39:38]} : {3'h0, sh[39]});
              sh <= sh << step;
            end else begin
              oe_n <= 4'hf;
            end
          end
        end
        HS_END: if (half_done) begin
          cs_n <= 1'b1;
          oe_n <= 4'hf;
          st <= HS_GAP;
        end
        default: if (half_done) begin
          if (exit_phase) begin
            exit_phase <= 1'b0;
            cont <= 1'b0;
            ci <= 7'h00;
            cs_n <= 1'b0;
            st <= HS_LOW;
            n_out <= cpb;
            n_in0 <= cpb;
            n_total <= cpb;
            sh <= {cmd[`CMD_OP], 32'h0} << step;
            io_o <= (lane == L4) ? cmd[7:4] :
                    ((lane == L2) ? {2'h0, cmd[7:6]} : {3'h0, cmd[7]});
            oe_n <= (lane == L4) ? 4'h0 : ((lane == L2) ? 4'hc : 4'he);
          end else begin
            st <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.host_io = io_o;
  assign link.host_io_oe_n = oe_n;
endmodule
`default_nettype wire

// File: rtl/sfdp_cfg.svh
// Constants for the parameter-table, reset and status-write link
`ifndef SFDP_CFG_SVH
`define SFDP_CFG_SVH

`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_WREN 8'h06
`define OP_VWREN 8'h50
`define OP_WRSR 8'h01
`define OP_RDSR 8'h05
`define OP_RDSFDP 8'h5a

`define SFDP_DW16_WORD 22'h00001a
`define ENTER4B_FIELD 8'h80
`define EXIT4B_FIELD 10'h300
`define SRST_FIELD 6'h30
`define DW16_RFU7 1'b1
`define SR1_WR_FIELD 7'h68
`define SFDP_FILL 8'hff
`define NV_SR_INIT 6'h00
`define ADDR_BYTES 3'h3

`define REG_CMD 3'h0
`define REG_TX 3'h1
`define REG_RX 3'h2
`define REG_STAT 3'h3
`define REG_CFG 3'h4
`define CMD_OP 7:0
`define CMD_TXN 10:8
`define CMD_RXN 13:11
`define CMD_DUMMY 14
`define CFG_LANE 1:0
`define CFG_CONT 2

`define CORE_MHZ 50
`define SCLK_HALF_NS 160
`define SCLK_HALF_CYC ((`SCLK_HALF_NS * `CORE_MHZ) / 1000)
`define EXIT_MODE_CLKS 7'h08
`define EXIT_MODE_NIBBLE 4'hf

`endif

// File: rtl/sfdp_pkg.sv
// Shared types of the flash end and the controller end
`default_nettype none
package sfdp_pkg;
  typedef enum logic [1:0] {L1 = 2'b00, L2 = 2'b01, L4 = 2'b10} lane_t;
  typedef enum logic [2:0] {
    DS_OP = 3'b000, DS_ADDR = 3'b001, DS_DUMMY = 3'b011, DS_DATA = 3'b010,
    DS_WDATA = 3'b110, DS_DONE = 3'b111
  } dev_st_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_LOW = 3'b001, HS_HIGH = 3'b011, HS_END = 3'b010,
    HS_GAP = 3'b110
  } host_st_t;
endpackage
`default_nettype wire

// File: rtl/spi_link_if.sv
// Serial link between controller and flash, with line resolution
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_io;
  logic [3:0] host_io_oe_n;
  logic [3:0] dev_io;
  logic [3:0] dev_io_oe_n;
  wire logic [3:0] io_bus;
  // Undriven lines float high as with pull-ups
  for (genvar i = 0; i < 4; i++) begin : g_res
    assign io_bus[i] = !host_io_oe_n[i] ? host_io[i] :
                       (!dev_io_oe_n[i] ? dev_io[i] : 1'b1);
  end
  modport flash (input sclk, cs_n, io_bus, output dev_io, dev_io_oe_n);
  modport ctrl (output sclk, cs_n, host_io, host_io_oe_n, input io_bus);
endinterface
`default_nettype wire

// File: verification/sfdp_dword16_reset_sr_write_tb_top.sv
// Bench joining controller end and flash end over the serial link
`default_nettype none
module sfdp_dword16_reset_sr_write_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sfdp_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  lane_t bus_width_i = L1;
  logic [7:0] status_o;
  logic [7:0] nv_status_o;
  logic wel_o;
  logic vol_en_o;
  logic reset_armed_o;
  logic soft_reset_o;
  int errors = 0;
  int num_checks = 0;
  int pulses = 0;
  int p;
  logic [31:0] rd;
  lane_t lanes [3] = '{L1, L2, L4};

  spi_link_if link_if();
  host_end host_end_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link_if.ctrl));
  flash_end flash_end_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link_if.flash),
    .bus_width_i(bus_width_i), .status_o(status_o), .nv_status_o(nv_status_o), .wel_o(wel_o),
    .vol_en_o(vol_en_o), .reset_armed_o(reset_armed_o), .soft_reset_o(soft_reset_o));
  sfdp_link_props sfdp_link_props_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sclk(link_if.sclk), .cs_n(link_if.cs_n), .dev_io_oe_n(link_if.dev_io_oe_n),
    .status_o(status_o), .nv_status_o(nv_status_o), .wel_o(wel_o), .vol_en_o(vol_en_o),
    .reset_armed_o(reset_armed_o), .soft_reset_o(soft_reset_o));

  initial forever #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (soft_reset_o === 1'b1) pulses++;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] act, input logic [31:0] exp, input string what);
    num_checks++;
    if (act !== exp) begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, act, exp);
    end
  endtask

  task automatic cmp1(input logic act, input logic exp, input string what);
    num_checks++;
    if (act !== exp) begin
      errors++;
      $display("BAD %0t %s got %b expected %b", $time, what, act, exp);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge itself, before it updates them
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk_i);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 5000) begin
        errors++;
        report_and_stop();
      end
      @(posedge core_clk_i);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic run(input logic [7:0] op, input logic [2:0] txn, input logic [2:0] rxn,
      input logic dum, input logic [31:0] tx);
    int n;
    av(1'b1, 3'h1, tx);
    av(1'b1, 3'h0, {17'h0, dum, rxn, txn, op});
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0) begin
      av(1'b0, 3'h3, 32'h0);
      n++;
      if (n > 3000) begin
        errors++;
        report_and_stop();
      end
    end
  endtask

  task automatic set_lane(input lane_t l, input logic cont);
    @(posedge core_clk_i);
    bus_width_i <= l;
    av(1'b1, 3'h4, {29'h0, cont, l});
  endtask

  task automatic t_table();
    logic [31:0] dw;
    run(8'h5a, 3'h3, 3'h4, 1'b1, 32'h68);
    cmp1(link_if.cs_n, 1'b1, "select idle");
    cmp1(link_if.sclk, 1'b0, "clock idle");
    av(1'b0, 3'h2, 32'h0);
    cmp32(rd, 32'he830c080, "table bytes");
    dw = {rd[7:0], rd[15:8], rd[23:16], rd[31:24]};
    cmp32({24'h0, dw[31:24]}, 32'h80, "entry field");
    cmp32({22'h0, dw[23:14]}, 32'h300, "exit field");
    cmp32({25'h0, dw[13:7]}, 32'h61, "reset field and bit 7");
    run(8'h5a, 3'h3, 3'h1, 1'b1, 32'h6c);
    av(1'b0, 3'h2, 32'h0);
    // Receive register keeps earlier bytes above the newest one
    cmp32(rd, 32'h30c080ff, "byte past table");
    av(1'b1, 3'h7, 32'hffffffff);
    av(1'b0, 3'h7, 32'h0);
    cmp32(rd, 32'h0, "unmapped read");
  endtask

  // Last pass runs on four lines with continuous read flagged, forcing the exit frame
  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      set_lane(lanes[i], i == 2);
      p = pulses;
      run(8'h66, 3'h0, 3'h0, 1'b0, 32'h0);
      cmp1(reset_armed_o, 1'b1, "reset armed");
      run(8'h99, 3'h0, 3'h0, 1'b0, 32'h0);
      cmp32(pulses - p, 32'h1, "reset pulse");
      cmp1(reset_armed_o, 1'b0, "arm spent");
    end
    av(1'b0, 3'h3, 32'h0);
    cmp1(rd[2], 1'b0, "continuous flag cleared");
    av(1'b0, 3'h4, 32'h0);
    cmp32(rd, 32'h2, "config after exit");
    set_lane(L1, 1'b0);
  endtask

  task automatic t_stray();
    p = pulses;
    run(8'h99, 3'h0, 3'h0, 1'b0, 32'h0);
    cmp32(pulses - p, 32'h0, "reset without enable");
    run(8'h66, 3'h0, 3'h0, 1'b0, 32'h0);
    run(8'h06, 3'h0, 3'h0, 1'b0, 32'h0);
    cmp1(reset_armed_o, 1'b0, "arm cancelled");
    run(8'h99, 3'h0, 3'h0, 1'b0, 32'h0);
    cmp32(pulses - p, 32'h0, "reset after cancel");
  endtask

  task automatic t_status();
    run(8'h06, 3'h0, 3'h0, 1'b0, 32'h0);
    cmp1(wel_o, 1'b1, "write enable set");
    run(8'h01, 3'h1, 3'h0, 1'b0, 32'hfc);
    cmp32({24'h0, status_o}, 32'hfc, "status written");
    cmp32({24'h0, nv_status_o}, 32'hfc, "stored copy written");
    cmp1(wel_o, 1'b0, "write enable spent");
    cmp1(rd[3], 1'b0, "enable flag spent");
    run(8'h50, 3'h0, 3'h0, 1'b0, 32'h0);
    cmp1(vol_en_o, 1'b1, "volatile enable set");
    cmp1(rd[3], 1'b1, "enable flag sent");
    run(8'h01, 3'h1, 3'h0, 1'b0, 32'h3c);
    cmp32({24'h0, status_o}, 32'h3c, "volatile override");
    cmp32({24'h0, nv_status_o}, 32'hfc, "stored copy kept");
    run(8'h01, 3'h1, 3'h0, 1'b0, 32'h00);
    cmp32({24'h0, status_o}, 32'h3c, "write without enable");
    run(8'h05, 3'h0, 3'h1, 1'b0, 32'h0);
    av(1'b0, 3'h2, 32'h0);
    cmp32(rd, 32'hc080ff3c, "status read over link");
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    cmp32({24'h0, status_o}, 32'hfc, "power-up load");
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_table();
    t_reset();
    t_stray();
    t_status();
    report_and_stop();
  end

  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: verification/sfdp_link_props.sv
// Link and flash-state checks for the reset pair and status writes
`default_nettype none
module sfdp_link_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dev_io_oe_n,
  input wire logic [7:0] status_o,
  input wire logic [7:0] nv_status_o,
  input wire logic wel_o,
  input wire logic vol_en_o,
  input wire logic reset_armed_o,
  input wire logic soft_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_reset_done;
    soft_reset_o ##1 !soft_reset_o;
  endsequence
  sequence s_in_frame;
    !cs_n ##1 !cs_n;
  endsequence
  chk_power_up_state: assert property ($fell(rst_i) |-> cs_n && !sclk && !wel_o
    && !reset_armed_o && status_o == nv_status_o)
    else $error("state not idle after reset");
  chk_sclk_idle_low: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock moved outside a frame");
  chk_dev_release: assert property (s_frame_end |-> ##[0:4] dev_io_oe_n == 4'hf)
    else $error("flash kept driving after deselect");
  chk_pulse_single: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
  chk_reset_needs_arm: assert property (soft_reset_o |-> $past(reset_armed_o))
    else $error("soft reset without prior enable");
  chk_reset_clears_en: assert property (s_reset_done |->
    !wel_o && !vol_en_o && !reset_armed_o)
    else $error("enables survived soft reset");
  chk_reset_in_gap: assert property (soft_reset_o |-> cs_n)
    else $error("soft reset inside a frame");
  chk_status_frame: assert property (s_in_frame |-> $stable(status_o))
    else $error("status changed inside a frame");
  chk_wel_bit: assert property (status_o[1:0] == {wel_o, 1'b0})
    else $error("status low bits disagree with write enable");
  chk_sr_needs_en: assert property ($changed(status_o[7:2]) |->
    $past(wel_o) || $past(vol_en_o))
    else $error("status changed without a write enable");
endmodule
`default_nettype wire
